// ===== design/flash_host_defs.svh
/*
 * Register offsets, field positions, command words and timing figures for the
 * flash protection/identifier host controller.
 * Assumes a word-wide parallel flash on the far side and a 40 MHz pclk.
 */
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define REG_CTRL      8'h00
`define REG_CFG       8'h04
`define REG_ADDR      8'h08
`define REG_WDATA     8'h0c
`define REG_RDATA     8'h10
`define REG_STATUS    8'h14
`define REG_MAPIDX    8'h18
`define REG_MAPDATA   8'h1c

`define CTRL_START    8
`define CFG_WP        0
`define CFG_TEMP      1
`define ST_ERR        2

`define CFG_RESET     2'h1

`define ITEM_GROUP    2'h2
`define ITEM_REGION   2'h3
`define LAST_GROUP    5'h1f

`define UNLOCK1_ADDR  22'h00_0555
`define UNLOCK2_ADDR  22'h00_02aa
`define DATA_UNLOCK1  16'h00aa
`define DATA_UNLOCK2  16'h0055
`define CMD_ID        16'h0090
`define CMD_ENTER     16'h0088
`define CMD_RESET     16'h00f0
`define CMD_EXIT2     16'h0000
`define CMD_PROTECT   16'h0060

`define CLK_NS        25
`define ACC_NS        100
`define WE_NS         50
`define RST_NS        500

`endif

// ===== design/flash_host_pkg.sv
/*
 * Types shared by the flash protection host controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package flash_host_pkg;

	typedef enum logic [3:0] {
		OP_READ    = 4'b0000,
		OP_WRITE   = 4'b0001,
		OP_ID_HV   = 4'b0010,
		OP_ID_CMD  = 4'b0011,
		OP_SCAN    = 4'b0100,
		OP_PROTECT = 4'b0101,
		OP_UNPROT  = 4'b0110,
		OP_ENTER   = 4'b0111,
		OP_EXIT    = 4'b1000,
		OP_HWRST   = 4'b1001
	} op_t;

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_SETUP  = 3'b001,
		S_STROBE = 3'b010,
		S_HOLD   = 3'b011,
		S_STEP   = 3'b100,
		S_RST    = 3'b101
	} state_t;

endpackage : flash_host_pkg

// ===== design/group_status_mem.sv
/*
 * Small memory holding the protection status byte read back per sector group.
 * Assumes one writer and one reader in the pclk domain; read data registered.
 */
`timescale 1ns/1ps

module group_status_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data_ff
);

	logic [WIDTH-1:0] mem_ff [DEPTH];

	// array carries no reset: contents are meaningless until a scan ran
	always_ff @(posedge pclk)
	begin
		if (wr_en)
			mem_ff[wr_addr] <= wr_data;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_data_ff <= '0;
		else
			rd_data_ff <= mem_ff[rd_addr];
	end

endmodule : group_status_mem

// ===== design/flash_protect_host.sv
/*
 * APB-controlled host that drives a word-wide flash through its pins for
 * identifier readout, group protection, temporary unprotect and the secured region.
 * Assumes board drivers turn id_hv_en / reset_hv_en into the elevated voltage
 * and a zero-wait flash data path sampled synchronously to pclk.
 */
`timescale 1ns/1ps
`include "flash_host_defs.svh"

module flash_protect_host #(
	parameter int ACC_NS = `ACC_NS,
	parameter int WE_NS  = `WE_NS,
	parameter int RST_NS = `RST_NS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [21:0] flash_addr,
	output logic      [15:0] dq_out,
	output logic             dq_oe,
	input  wire logic [15:0] dq_in,
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic             flash_reset_n,
	output logic             reset_hv_en,
	output logic             id_hv_en,
	output logic             wp_n
);
	import flash_host_pkg::*;

	localparam int ACC_CYC = (ACC_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int WE_CYC  = (WE_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int RST_CYC = (RST_NS + `CLK_NS - 1) / `CLK_NS;

	state_t      state_ff;
	op_t         op_ff;
	logic [2:0]  step_ff;
	logic [4:0]  grp_ff;
	logic [7:0]  cnt_ff;
	logic [21:0] addr_reg_ff;
	logic [15:0] wdata_reg_ff;
	logic [15:0] rdata_ff;
	logic [4:0]  idx_ff;
	logic [7:0]  map_rd;
	logic        cfg_wp_n_ff, cfg_temp_ff, err_ff, region_ff, flock_ff, gprot_ff;
	logic        pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	logic        p_wr, p_hv, p_last, busy, acc, commit, go, refuse;
	logic [21:0] p_addr;
	logic [15:0] p_data;
	logic [7:0]  strobe_last;

	function automatic logic [37:0] seq_word(input logic [2:0] s, input logic [15:0] c2,
		input logic [15:0] c3);
		unique case (s)
			3'd0:    seq_word = {`UNLOCK1_ADDR, `DATA_UNLOCK1};
			3'd1:    seq_word = {`UNLOCK2_ADDR, `DATA_UNLOCK2};
			3'd2:    seq_word = {`UNLOCK1_ADDR, c2};
			default: seq_word = {22'h00_0000, c3};
		endcase
	endfunction : seq_word

	function automatic logic [21:0] id_addr(input logic [1:0] item, input logic [6:0] sect);
		id_addr = {sect, 13'h0000, item};
	endfunction : id_addr

	function automatic logic [21:0] prot_addr(input logic [6:0] sect, input logic a6);
		prot_addr = {sect, 8'h00, a6, 4'h0, `ITEM_GROUP};
	endfunction : prot_addr

	assign busy        = (state_ff != S_IDLE);
	assign acc         = psel && penable && !pready_ff;
	assign commit      = psel && penable && pready_ff && pwrite && !pslverr_ff;
	assign go          = commit && paddr == `REG_CTRL && pwdata[`CTRL_START];
	// array access while the secured region is mapped is only allowed in the first sector
	assign refuse      = busy || pwdata[3:0] > OP_HWRST || (region_ff
		&& pwdata[3:0] <= OP_WRITE && addr_reg_ff[21:15] != 7'h00);
	assign strobe_last = p_wr ? 8'(WE_CYC - 1) : 8'(ACC_CYC - 1);

	always_comb
	begin
		p_wr   = 1'b0;
		p_hv   = 1'b0;
		p_last = 1'b1;
		p_addr = addr_reg_ff;
		p_data = wdata_reg_ff;
		unique case (op_ff)
			OP_READ: p_wr = 1'b0;
			OP_WRITE: p_wr = 1'b1;
			OP_ID_HV:
			begin
				p_addr = id_addr(addr_reg_ff[1:0], addr_reg_ff[21:15]);
				p_hv   = 1'b1;
			end
			OP_ID_CMD:
			begin
				p_last = (step_ff == 3'd4);
				p_wr   = (step_ff != 3'd3);
				{p_addr, p_data} = seq_word(step_ff, `CMD_ID, `CMD_RESET);
				if (step_ff == 3'd3)
					p_addr = id_addr(addr_reg_ff[1:0], addr_reg_ff[21:15]);
			end
			OP_SCAN:
			begin
				p_addr = id_addr(`ITEM_GROUP, {grp_ff, 2'b00});
				p_hv   = 1'b1;
			end
			OP_PROTECT:
			begin
				p_wr   = 1'b1;
				p_addr = prot_addr(addr_reg_ff[21:15], 1'b0);
				p_data = `CMD_PROTECT;
			end
			OP_UNPROT:
			begin
				p_wr   = (step_ff != 3'd0);
				p_hv   = (step_ff == 3'd0);
				p_data = `CMD_PROTECT;
				p_addr = (step_ff == 3'd0) ? id_addr(`ITEM_GROUP, {grp_ff, 2'b00}) :
					prot_addr({grp_ff, 2'b00}, step_ff == 3'd2);
			end
			OP_ENTER:
			begin
				p_wr   = 1'b1;
				p_last = (step_ff == 3'd2);
				{p_addr, p_data} = seq_word(step_ff, `CMD_ENTER, `CMD_EXIT2);
			end
			OP_EXIT:
			begin
				p_wr   = 1'b1;
				p_last = (step_ff == 3'd3);
				{p_addr, p_data} = seq_word(step_ff, `CMD_ID, `CMD_EXIT2);
			end
			OP_HWRST: p_wr = 1'b0;
			default: p_wr = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= S_IDLE;
			op_ff    <= OP_READ;
			step_ff  <= 3'd0;
			grp_ff   <= 5'h00;
			cnt_ff   <= 8'h00;
		end
		else
		begin
			unique case (state_ff)
				S_IDLE:
				if (go && !refuse)
				begin
					op_ff    <= op_t'(pwdata[3:0]);
					step_ff  <= 3'd0;
					grp_ff   <= 5'h00;
					cnt_ff   <= 8'h00;
					state_ff <= (op_t'(pwdata[3:0]) == OP_HWRST) ? S_RST : S_SETUP;
				end
				S_SETUP:
				begin
					cnt_ff   <= 8'h00;
					state_ff <= S_STROBE;
				end
				S_STROBE:
				if (cnt_ff == strobe_last)
					state_ff <= S_HOLD;
				else
					cnt_ff <= cnt_ff + 8'h01;
				S_HOLD: state_ff <= S_STEP;
				S_STEP:
				begin
					state_ff <= S_SETUP;
					if (op_ff == OP_SCAN)
					begin
						if (grp_ff == `LAST_GROUP)
							state_ff <= S_IDLE;
						grp_ff <= grp_ff + 5'h01;
					end
					else if (op_ff == OP_UNPROT)
					begin
						// re-verify after each protect write; unprotect only once all read back set
						if (step_ff == 3'd0 && !rdata_ff[0])
							step_ff <= 3'd1;
						else if (step_ff == 3'd0 && grp_ff == `LAST_GROUP)
							step_ff <= 3'd2;
						else if (step_ff == 3'd0)
							grp_ff <= grp_ff + 5'h01;
						else if (step_ff == 3'd1)
							step_ff <= 3'd0;
						else
							state_ff <= S_IDLE;
					end
					else if (p_last)
						state_ff <= S_IDLE;
					else
						step_ff <= step_ff + 3'd1;
				end
				S_RST:
				if (cnt_ff == 8'(RST_CYC - 1))
					state_ff <= S_IDLE;
				else
					cnt_ff <= cnt_ff + 8'h01;
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// pins lag the state by one cycle, so oe/we low covers exactly the strobe count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flash_addr    <= 22'h00_0000;
			dq_out        <= 16'h0000;
			dq_oe         <= 1'b0;
			ce_n          <= 1'b1;
			oe_n          <= 1'b1;
			we_n          <= 1'b1;
			flash_reset_n <= 1'b1;
			id_hv_en      <= 1'b0;
			reset_hv_en   <= 1'b0;
			wp_n          <= 1'b1;
		end
		else
		begin
			if (state_ff == S_SETUP)
			begin
				flash_addr <= p_addr;
				dq_out     <= p_data;
			end
			ce_n          <= !(state_ff inside {S_SETUP, S_STROBE, S_HOLD});
			dq_oe         <= p_wr && (state_ff inside {S_SETUP, S_STROBE, S_HOLD});
			oe_n          <= !(state_ff == S_STROBE && !p_wr);
			we_n          <= !(state_ff == S_STROBE && p_wr);
			flash_reset_n <= (state_ff != S_RST);
			id_hv_en      <= busy && state_ff != S_RST && p_hv;
			reset_hv_en   <= cfg_temp_ff || (busy && op_ff inside {OP_PROTECT, OP_UNPROT});
			wp_n          <= cfg_wp_n_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_ff <= 16'h0000;
			flock_ff <= 1'b0;
			gprot_ff <= 1'b0;
		end
		else if (state_ff == S_HOLD && !p_wr)
		begin
			rdata_ff <= dq_in;
			if (p_addr[1:0] == `ITEM_REGION && op_ff inside {OP_ID_HV, OP_ID_CMD})
				flock_ff <= dq_in[7];
			if (p_addr[1:0] == `ITEM_GROUP && op_ff != OP_READ)
				gprot_ff <= dq_in[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			region_ff <= 1'b0;
		else if (state_ff == S_STEP && p_last && op_ff == OP_ENTER)
			region_ff <= 1'b1;
		else if ((state_ff == S_STEP && p_last && op_ff == OP_EXIT) || state_ff == S_RST)
			region_ff <= 1'b0;
	end

	group_status_mem #(.WIDTH(8), .DEPTH(32), .AW(5)) u_map (
		.pclk       (pclk),
		.presetn    (presetn),
		.wr_en      (state_ff == S_HOLD && op_ff == OP_SCAN),
		.wr_addr    (grp_ff),
		.wr_data    (dq_in[7:0]),
		.rd_addr    (idx_ff),
		.rd_data_ff (map_rd)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg_wp_n_ff  <= 1'(`CFG_RESET);
			cfg_temp_ff  <= 1'b0;
			addr_reg_ff  <= 22'h00_0000;
			wdata_reg_ff <= 16'h0000;
			idx_ff       <= 5'h00;
		end
		else if (commit)
		begin
			unique case (paddr)
				`REG_CFG:    {cfg_temp_ff, cfg_wp_n_ff} <= pwdata[`CFG_TEMP:`CFG_WP];
				`REG_ADDR:   addr_reg_ff <= pwdata[21:0];
				`REG_WDATA:  wdata_reg_ff <= pwdata[15:0];
				`REG_MAPIDX: idx_ff <= pwdata[4:0];
				default:     idx_ff <= idx_ff;
			endcase
		end
	end

	// a refused start sets the flag even while software clears it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_ff <= 1'b0;
		else if (go && refuse)
			err_ff <= 1'b1;
		else if (commit && paddr == `REG_STATUS && pwdata[`ST_ERR])
			err_ff <= 1'b0;
	end

	// one wait state: answer registered on the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else
		begin
			pready_ff  <= acc;
			pslverr_ff <= acc && !(paddr inside {`REG_CTRL, `REG_CFG, `REG_ADDR, `REG_WDATA,
				`REG_RDATA, `REG_STATUS, `REG_MAPIDX, `REG_MAPDATA});
			prdata_ff  <= 32'h0000_0000;
			if (acc && !pwrite)
			begin
				unique case (paddr)
					`REG_CTRL:    prdata_ff <= {28'h000_0000, op_ff};
					`REG_CFG:     prdata_ff <= {30'h0000_0000, cfg_temp_ff, cfg_wp_n_ff};
					`REG_ADDR:    prdata_ff <= {10'h000, addr_reg_ff};
					`REG_WDATA:   prdata_ff <= {16'h0000, wdata_reg_ff};
					`REG_RDATA:   prdata_ff <= {16'h0000, rdata_ff};
					`REG_STATUS:  prdata_ff <= {27'h000_0000, gprot_ff, flock_ff, err_ff,
						region_ff, busy};
					`REG_MAPIDX:  prdata_ff <= {27'h000_0000, idx_ff};
					`REG_MAPDATA: prdata_ff <= {24'h00_0000, map_rd};
					default:      prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign prdata  = prdata_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_enter_done;
		state_ff == S_STEP && op_ff == OP_ENTER && p_last;
	endsequence
	sequence s_we_fall;
		$fell(we_n) && !ce_n && dq_oe;
	endsequence

	a_hv_id_held: assert property (state_ff == S_HOLD && p_hv |-> id_hv_en && !oe_n)
		else $error("id select voltage dropped during read");
	a_id_addr_shape: assert property (state_ff == S_HOLD && !p_wr && op_ff inside {OP_ID_HV,
		OP_ID_CMD, OP_SCAN} |-> !flash_addr[6] && we_n && !ce_n)
		else $error("identifier read with bad A6 or strobes");
	a_scan_group: assert property (state_ff == S_HOLD && op_ff == OP_SCAN |->
		flash_addr[21:17] == grp_ff && flash_addr[1:0] == `ITEM_GROUP)
		else $error("scan read addresses wrong group");
	a_prot_needs_hv: assert property (!we_n && op_ff inside {OP_PROTECT, OP_UNPROT} |->
		reset_hv_en)
		else $error("protect write without elevated reset");
	a_unprot_order: assert property (state_ff == S_SETUP && op_ff == OP_UNPROT &&
		step_ff == 3'd2 |-> grp_ff == `LAST_GROUP && rdata_ff[0])
		else $error("unprotect before all groups protected");
	a_region_enter: assert property (s_enter_done |=> region_ff ##1 region_ff)
		else $error("region not mapped after enter");
	a_region_reset: assert property (state_ff == S_RST |=> !region_ff && !flash_reset_n)
		else $error("region mapping survived hardware reset");
	a_temp_exit: assert property ($fell(cfg_temp_ff) && !busy |=> !reset_hv_en)
		else $error("elevated reset kept after temporary unprotect");
	a_wp_follow: assert property (cfg_temp_ff |=> reset_hv_en && wp_n == $past(cfg_wp_n_ff))
		else $error("temp unprotect or write-protect not driven");
	a_write_pulse: assert property (s_we_fall |-> $stable(flash_addr) ##1 dq_oe[*1])
		else $error("write strobe without held address and data");

endmodule : flash_protect_host

// ===== verification/flash_model.sv
/*
 * Behavioural word-wide flash: identifier codes, group protection, secured region.
 * Assumes the host drives ce_n/oe_n/we_n and places write data on dq_out.
 */
`timescale 1ns/1ps

module flash_model #(
	parameter logic        LOCK     = 1'b1,
	parameter logic [15:0] MFR_CODE = 16'h00c3, // arbitrary
	parameter logic [15:0] DEV_CODE = 16'h4a5e  // arbitrary
) (
	input  wire logic [21:0] flash_addr,
	input  wire logic [15:0] dq_out,
	input  wire logic        dq_oe,
	output logic      [15:0] dq_in,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        flash_reset_n,
	input  wire logic        reset_hv_en,
	input  wire logic        id_hv_en,
	output int               viol
);
	logic [31:0] prot = '0;
	logic [1:0]  step = '0;
	logic        id_mode = 0;
	logic        region = 0;
	logic        exit_arm = 0;
	logic [15:0] rd;
	logic [15:0] last_q = '0;

	initial viol = 0;

	always @(posedge we_n or negedge flash_reset_n)
	begin
		if (!flash_reset_n)
		begin
			region = 0;
			id_mode = 0;
			step = 0;
		end
		else if (!ce_n && dq_oe)
		begin
			if (dq_out == 16'h00f0)
			begin
				id_mode = 0;
				step = 0;
			end
			else if (dq_out == 16'h0060 && reset_hv_en)
			begin
				if (!flash_addr[6])
					prot[flash_addr[21:17]] = 1'b1;
				else
				begin
					if (prot != '1)
						viol++;
					prot = '0;
				end
			end
			else if (exit_arm && dq_out == 16'h0000)
			begin
				region = 0;
				id_mode = 0;
				exit_arm = 0;
			end
			else
				case (step)
					2'd0: step = (flash_addr == 22'h00_0555 && dq_out == 16'h00aa) ? 2'd1 : 2'd0;
					2'd1: step = (flash_addr == 22'h00_02aa && dq_out == 16'h0055) ? 2'd2 : 2'd0;
					default:
					begin
						step = 0;
						if (dq_out == 16'h0090)
						begin
							id_mode = 1;
							exit_arm = region;
						end
						if (dq_out == 16'h0088)
							region = 1;
					end
				endcase
		end
	end

	always_comb
	begin
		if ((id_mode || id_hv_en) && !flash_addr[6])
			case (flash_addr[1:0])
				2'd0: rd = MFR_CODE;
				2'd1: rd = DEV_CODE;
				2'd2: rd = {15'h0000, prot[flash_addr[21:17]]};
				default: rd = {8'h00, LOCK, 7'h18};
			endcase
		else if (region && flash_addr[21:15] == 7'h00)
			rd = (LOCK && flash_addr[6:0] > 7'h07) ? 16'hffff : (16'h5e00 | flash_addr[6:0]);
		else
			rd = flash_addr[15:0] ^ 16'ha5a5;
	end

	// released bus shows the inverse so a stale value never matches
	always @(posedge oe_n)
		last_q = rd;
	assign dq_in = (!ce_n && !oe_n) ? rd : ~last_q;
endmodule : flash_model

// ===== verification/flash_protect_host_test.sv
/*
 * Self-checking bench for the flash protection host, APB master plus flash model.
 * Assumes the design files and flash_host_defs.svh are on the include path.
 */
`timescale 1ns/1ps
`include "flash_host_defs.svh"

module flash_protect_host_test;
	import flash_host_pkg::*;
	localparam logic        LOCK = 1'b1;
	localparam logic [15:0] MFR  = 16'h00c3; // arbitrary
	localparam logic [15:0] DEV  = 16'h4a5e; // arbitrary
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [21:0] flash_addr;
	logic [15:0] dq_out;
	logic [15:0] dq_in;
	logic        dq_oe, ce_n, oe_n, we_n, flash_reset_n, reset_hv_en, id_hv_en, wp_n;
	int          n_errors = 0;
	int          n_checks = 0;
	int          viol;
	int          g;
	logic        serr;
	logic [31:0] rd;
	logic [31:0] pm;
	logic [21:0] wa;
	logic [15:0] wd;
	logic [15:0] wv;

	always #12.5 pclk = ~pclk;

	// what the flash latched on the closing edge of the last write strobe
	always @(posedge we_n)
		if (ce_n === 1'b0)
		begin
			wa = flash_addr;
			wd = dq_out;
		end

	flash_protect_host DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .flash_addr, .dq_out, .dq_oe, .dq_in, .ce_n, .oe_n,
		.we_n, .flash_reset_n, .reset_hv_en, .id_hv_en, .wp_n);
	flash_model #(.LOCK(LOCK), .MFR_CODE(MFR), .DEV_CODE(DEV)) model (.flash_addr, .dq_out,
		.dq_oe, .dq_in, .ce_n, .oe_n, .we_n, .flash_reset_n, .reset_hv_en, .id_hv_en, .viol);

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// an edge always passes before a new setup, so psel is never driven twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task automatic op(input logic [3:0] o, input logic [21:0] a);
		apb(1, `REG_ADDR, {10'h000, a});
		apb(1, `REG_CTRL, 32'h0000_0100 | o);
		do
			apb(0, `REG_STATUS, 0);
		while (rd[0] !== 1'b0);
	endtask : op

	task automatic scan_chk(input logic [31:0] p);
		op(OP_SCAN, 0);
		for (int i = 0; i < 32; i++)
		begin
			apb(1, `REG_MAPIDX, i);
			apb(0, `REG_MAPDATA, 0);
			chk("group map", {31'h0, p[i]}, rd);
		end
	endtask : scan_chk

	function automatic logic [31:0] id_exp(input logic [1:0] it, input logic p);
		case (it)
			2'd0: return {16'h0000, MFR};
			2'd1: return {16'h0000, DEV};
			2'd2: return {31'h0, p};
			default: return {24'h00_0000, LOCK, 7'h18};
		endcase
	endfunction : id_exp

	initial
	begin
		repeat (90000) @(posedge pclk);
		n_errors++;
		summarize();
	end

	initial
	begin
		void'($urandom(72251));
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("wp_n", 1, wp_n);
		apb(0, `REG_CFG, 0);
		chk("cfg reset", `CFG_RESET, rd);
		apb(0, 8'h40, 0);
		chk("unmapped", 1, serr);
		for (int i = 0; i < 4; i++)
		begin
			g = $urandom_range(31, 0);
			op(OP_ID_HV, (g << 17) | i);
			apb(0, `REG_RDATA, 0);
			chk("id hv", id_exp(i, 0), rd);
		end
		apb(0, `REG_STATUS, 0);
		chk("lock bit", LOCK, rd[3]);
		for (int i = 0; i < 2; i++)
		begin
			op(OP_ID_CMD, i);
			apb(0, `REG_RDATA, 0);
			chk("id cmd", id_exp(i, 0), rd);
		end
		pm = '0;
		g = $urandom_range(30, 1);
		for (int k = 0; k < 32; k++)
			if (k == 0 || k == 31 || k == g)
			begin
				op(OP_PROTECT, k << 17);
				pm[k] = 1'b1;
				op(OP_ID_HV, (k << 17) | 2);
				apb(0, `REG_STATUS, 0);
				chk("verify bit", 1, rd[4]);
			end
		wv = 16'($urandom);
		apb(1, `REG_WDATA, {16'h0000, wv});
		op(OP_WRITE, (g << 17) | 5);
		chk("write addr", (g << 17) | 5, wa);
		chk("write data", wv, wd);
		op(OP_READ, (g << 17) | 5);
		apb(0, `REG_RDATA, 0);
		chk("protected word", 32'h0000_a5a0, rd);
		scan_chk(pm);
		op(OP_UNPROT, 0);
		scan_chk(0);
		chk("protect first", 0, viol);
		op(OP_ENTER, 0);
		apb(0, `REG_STATUS, 0);
		chk("mapped", 1, rd[1]);
		op(OP_READ, 3);
		apb(0, `REG_RDATA, 0);
		chk("region word", 32'h0000_5e03, rd);
		op(OP_READ, 22'h00_8000);
		apb(0, `REG_STATUS, 0);
		chk("refused", 1, rd[2]);
		apb(1, `REG_STATUS, 4);
		apb(0, `REG_STATUS, 0);
		chk("err cleared", 0, rd[2]);
		op(OP_EXIT, 0);
		op(OP_READ, 3);
		apb(0, `REG_RDATA, 0);
		chk("array after exit", 32'h0000_a5a6, rd);
		op(OP_ENTER, 0);
		op(OP_HWRST, 0);
		apb(0, `REG_STATUS, 0);
		chk("unmapped after reset", 0, rd[1]);
		op(OP_READ, 3);
		apb(0, `REG_RDATA, 0);
		chk("array after reset", 32'h0000_a5a6, rd);
		op(4'hf, 0);
		apb(0, `REG_STATUS, 0);
		chk("bad op", 1, rd[2]);
		apb(1, `REG_CFG, 2);
		repeat (2) @(posedge pclk);
		chk("wp low", 0, wp_n);
		chk("temp hv", 1, reset_hv_en);
		apb(1, `REG_CFG, 1);
		repeat (2) @(posedge pclk);
		chk("hv off", 0, reset_hv_en);
		chk("wp high", 1, wp_n);
		summarize();
	end
endmodule : flash_protect_host_test
